// ### src/fault_alert_manager.sv
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fault_alert_manager import fam_pkg::*; #(
	parameter int WDT_CYCLES = WDT_CYC
) (
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// serial bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	output logic             alert_n_out,
	output logic             alert_n_oe,
	// device pins and sensors
	input  wire logic [3:0]  addr_pins,
	input  wire logic        high_side_enable_pin,
	input  wire logic        dimming_clock_input,
	input  wire logic        rt_resistor_fitted,
	input  wire sense_s      sense,
	// command layer, same clock
	input  wire wr_cmd_s     wr_cmd,
	// results
	output logic [NCH-1:0]   switch_force_on,
	output logic [1:0]       dim_clk_sel,
	output logic             dim_counter_reset,
	output logic             defaults_load
);
	localparam int SW = 2 + 2 + 4 + $bits(sense_s) + 1;
	localparam logic [SW-1:0] SYNC_IDLE = {2'h3, {(SW - 2){1'h0}}};
	logic [SW-1:0]  s1, s2;
	logic           scl_s, sda_s, en_s, dck_s, fit_s;
	logic [3:0]     adr_s;
	sense_s         sn;
	logic           scl_d, sda_d, dck_d;
	i2c_state_e     state;
	logic [7:0]     shreg, txb;
	logic [3:0]     bcnt;
	logic           rd_ara, bc_seen, ara_ok, bc_wr;
	logic           wd_run, wdt_to;
	logic [31:0]    wd_cnt, ctrl;
	logic [7:0]     ck_cnt;
	logic           clkf, clkf_alert;
	logic [NCH-1:0] open_st, short_st, open_raise, short_raise;
	logic           ovh_flag, ovh_d, armed;
	logic [7:0]     o_cnt [NCH];
	logic [7:0]     s_cnt [NCH];

	// first stage feeds only the second
	// bus lines reset to their idle high level: no false edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1 <= SYNC_IDLE;
			s2 <= SYNC_IDLE;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			dck_d <= 1'b0;
		end else begin
			s1 <= {scl_in, sda_in, high_side_enable_pin, dimming_clock_input, addr_pins, sense, rt_resistor_fitted};
			s2 <= s1;
			scl_d <= scl_s;
			sda_d <= sda_s;
			dck_d <= dck_s;
		end
	end
	assign {scl_s, sda_s, en_s, dck_s, adr_s, sn, fit_s} = s2;
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_c  = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_c   = scl_s & scl_d & ~sda_d & sda_s;
	wire tx_bit   = txb[3'(7 - bcnt)];

	// alert response responder
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			shreg <= '0;
			txb <= '0;
			bcnt <= '0;
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
			rd_ara <= 1'b0;
			bc_seen <= 1'b0;
			ara_ok <= 1'b0;
			bc_wr <= 1'b0;
		end else begin
			ara_ok <= 1'b0;
			bc_wr <= 1'b0;
			if (wdt_to) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
				bc_seen <= 1'b0;
			end else if (stop_c) begin
				state <= ST_IDLE;
				sda_oe <= 1'b0;
				bc_wr <= bc_seen;
				bc_seen <= 1'b0;
			end else if (start_c) begin
				state <= ST_ADDR;
				bcnt <= '0;
				sda_oe <= 1'b0;
				bc_seen <= 1'b0;
			end else begin
				case (state)
					ST_ADDR: begin
						if (scl_rise) begin
							shreg <= {shreg[6:0], sda_s};
							bcnt <= bcnt + 4'h1;
						end else if (scl_fall && bcnt == 4'h8) begin
							rd_ara <= shreg == ARA_RD;
							txb <= {ADDR_PFX, adr_s, 1'b1};
							if ((shreg == ARA_RD && alert_n_oe) || shreg == BCAST_WR) begin
								sda_oe <= 1'b1;
								bc_seen <= shreg == BCAST_WR;
								state <= ST_ACK;
							end else
								state <= ST_SKIP;
						end
					end
					ST_ACK: if (scl_fall) begin
						bcnt <= '0;
						sda_oe <= rd_ara & ~txb[7];
						state <= rd_ara ? ST_TX : ST_SKIP;
					end
					ST_TX: begin
						if (scl_rise) begin
							if (tx_bit && !sda_s) begin
								sda_oe <= 1'b0;
								state <= ST_SKIP;
							end else begin
								bcnt <= bcnt + 4'h1;
								ara_ok <= bcnt == 4'h7;
							end
						end else if (scl_fall) begin
							if (bcnt == 4'h8) begin
								sda_oe <= 1'b0;
								state <= ST_SKIP;
							end else
								sda_oe <= ~tx_bit;
						end
					end
					ST_IDLE, ST_SKIP: sda_oe <= 1'b0;
					default: state <= ST_IDLE;
				endcase
			end
		end
	end

	// watchdog: reset-like pulse when a transaction overstays
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_run <= 1'b1;
			wd_cnt <= '0;
			wdt_to <= 1'b0;
		end else begin
			wdt_to <= 1'b0;
			if (start_c) begin
				wd_run <= 1'b1;
				wd_cnt <= '0;
			end else if (stop_c) begin
				wd_run <= 1'b0;
			end else if (wd_run && ctrl[0]) begin
				if (wd_cnt == 32'(WDT_CYCLES - 1)) begin
					wdt_to <= 1'b1;
					wd_run <= 1'b0;
					wd_cnt <= '0;
				end else
					wd_cnt <= wd_cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			defaults_load <= 1'b1;
			dim_counter_reset <= 1'b1;
		end else begin
			defaults_load <= wdt_to;
			dim_counter_reset <= wdt_to | bc_wr;
		end
	end

	// clock input monitor; the count marks a period longer than the standby one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_cnt <= '0;
			clkf <= 1'b0;
			clkf_alert <= 1'b0;
			dim_clk_sel <= SEL_OFF;
		end else begin
			ck_cnt <= (dck_s & ~dck_d) ? 8'h0 : (ck_cnt == 8'(STBY_CYC) ? ck_cnt : ck_cnt + 8'h1);
			if (wdt_to || bc_wr) begin
				clkf <= 1'b0;
				clkf_alert <= 1'b0;
				dim_clk_sel <= en_s ? SEL_EXT : SEL_OFF;
			end else if (!en_s) begin
				dim_clk_sel <= SEL_OFF;
			end else if (clkf) begin
				dim_clk_sel <= SEL_STBY;
				if (ara_ok)
					clkf_alert <= 1'b0;
			end else if (ck_cnt == 8'(STBY_CYC)) begin
				if (fit_s)
					dim_clk_sel <= SEL_INT;
				else begin
					clkf <= 1'b1;
					clkf_alert <= 1'b1;
					dim_clk_sel <= SEL_STBY;
				end
			end else
				dim_clk_sel <= (dim_clk_sel == SEL_OFF) ? SEL_EXT : dim_clk_sel;
		end
	end

	// per-channel filters and status bits
	wire ovh_rise = sn.over_temp & ~ovh_d;
	wire wr_stop  = wr_cmd.stop & (wr_cmd.all | wr_cmd.single);
	wire ovh_clr  = wr_cmd.stop & wr_cmd.all & wr_cmd.data == ALL_ONES & sn.temp_cool;
	genvar ch;
	for (ch = 0; ch < NCH; ch++) begin : g_ch
		wire hit = wr_stop & (wr_cmd.all | wr_cmd.chan == 3'(ch));
		assign open_raise[ch]  = sn.open_abs[ch] | (o_cnt[ch] == 8'(FILT_CYC) & sn.open_thr[ch]);
		assign short_raise[ch] = s_cnt[ch] == 8'(FILT_CYC) & sn.short_thr[ch];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				o_cnt[ch] <= '0;
				s_cnt[ch] <= '0;
				open_st[ch] <= 1'b0;
				short_st[ch] <= 1'b0;
			end else if (wdt_to) begin
				o_cnt[ch] <= '0;
				s_cnt[ch] <= '0;
				open_st[ch] <= 1'b0;
				short_st[ch] <= 1'b0;
			end else begin
				o_cnt[ch] <= !sn.open_thr[ch] ? 8'h0 : (open_raise[ch] ? o_cnt[ch] : o_cnt[ch] + 8'h1);
				s_cnt[ch] <= !sn.short_thr[ch] ? 8'h0 : (short_raise[ch] ? s_cnt[ch] : s_cnt[ch] + 8'h1);
				// set wins; overheat bits need the dedicated clear
				if (open_raise[ch] || ovh_rise)
					open_st[ch] <= 1'b1;
				else if ((hit && !ovh_flag) || (ovh_flag && ovh_clr))
					open_st[ch] <= 1'b0;
				if (short_raise[ch] || ovh_rise)
					short_st[ch] <= 1'b1;
				else if ((hit && !ovh_flag) || (ovh_flag && ovh_clr))
					short_st[ch] <= 1'b0;
			end
		end
	end

	wire pending = (|open_st) | (|short_st) | clkf_alert;
	assign switch_force_on = open_st;
	wire new_evt = (|open_raise) | (|short_raise) | ovh_rise | (~clkf & fit_s == 1'b0 & ck_cnt == 8'(STBY_CYC) & en_s);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovh_d <= 1'b0;
			ovh_flag <= 1'b0;
			armed <= 1'b0;
			alert_n_oe <= 1'b0;
			alert_n_out <= 1'b0;
		end else begin
			ovh_d <= sn.over_temp;
			if (wdt_to) begin
				ovh_flag <= 1'b0;
				armed <= 1'b0;
			end else begin
				if (ovh_rise)
					ovh_flag <= 1'b1;
				else if (ovh_clr)
					ovh_flag <= 1'b0;
				// a new event or a write at STOP re-arms, beating the release
				if (new_evt || wr_stop)
					armed <= 1'b1;
				else if (ara_ok)
					armed <= 1'b0;
			end
			alert_n_oe <= armed & pending;
		end
	end

	// apb slave, one wait state
	wire acc = psel & penable & ~pready;
	wire hit_st = paddr == STATUS_OFS;
	wire hit_ct = paddr == CTRL_OFS;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			ctrl <= CTRL_RST;
		end else begin
			pready <= acc;
			pslverr <= acc & ~hit_st & ~hit_ct;
			if (wdt_to)
				ctrl <= CTRL_RST;
			else if (acc && pwrite && hit_ct)
				ctrl <= pwdata & CTRL_RST;
			if (acc && !pwrite)
				prdata <= hit_ct ? ctrl : (hit_st ? 32'({dim_clk_sel, alert_n_oe, clkf, ovh_flag, short_st, open_st}) : '0);
			else
				prdata <= '0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ara_ack: assert property (state == ST_ADDR && scl_fall && bcnt == 4'h8 && shreg == ARA_RD && alert_n_oe
		&& !start_c && !stop_c && !wdt_to |=> sda_oe && state == ST_ACK) else $error("ara not acked");
	a_arb_lost: assert property (state == ST_TX && scl_rise && tx_bit && !sda_s && !start_c && !stop_c && !wdt_to
		|=> !sda_oe && state == ST_SKIP) else $error("arbitration loss ignored");
	a_ara_release: assert property (ara_ok && !new_evt && !wr_stop && !wdt_to |=> !armed ##1 !alert_n_oe)
		else $error("alert not released");
	a_wdt_fire: assert property (wd_run && ctrl[0] && !start_c && !stop_c && wd_cnt == 32'(WDT_CYCLES - 1)
		|=> wdt_to ##1 defaults_load) else $error("watchdog missed");
	a_wdt_clear: assert property (wdt_to |=> open_st == '0 && short_st == '0 && ctrl == CTRL_RST)
		else $error("timeout left state");
	a_ovh_set: assert property (ovh_rise && !wdt_to |=> &open_st && &short_st && &switch_force_on)
		else $error("overheat not applied");
	a_open_abs: assert property (sn.open_abs[0] && !wdt_to |=> open_st[0] && switch_force_on[0])
		else $error("open fault missed");
	a_short_time: assert property ($rose(short_st[0]) && !$past(ovh_rise) |-> $past(s_cnt[0]) == 8'(FILT_CYC))
		else $error("short filter time wrong");
	a_stby_sel: assert property (en_s && !clkf && !fit_s && ck_cnt == 8'(STBY_CYC) && !wdt_to && !bc_wr
		|=> clkf && dim_clk_sel == SEL_STBY) else $error("standby not selected");
	a_apb_ready: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready timing"); 
	c_ara_done: cover property (ara_ok);
	c_wdt: cover property (wdt_to);
	c_ovh_clear: cover property (ovh_flag && ovh_clr);
	c_int_osc: cover property (dim_clk_sel == SEL_INT);
endmodule : fault_alert_manager

// ### src/fam_pkg.sv
package fam_pkg;
	localparam int CLK_HZ     = 10_000_000;
	localparam int FILT_NS    = 15_000;
	localparam int FILT_CYC   = (FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int STBY_HZ    = 100_000;
	localparam int STBY_CYC   = CLK_HZ / STBY_HZ;
	localparam int WDT_MS     = 16;
	localparam int WDT_CYC    = WDT_MS * (CLK_HZ / 1000);
	localparam int NCH        = 8;
	localparam logic [7:0] ARA_RD   = 8'h19;
	localparam logic [7:0] BCAST_WR = 8'h18;
	localparam logic [2:0] ADDR_PFX = 3'h2;
	localparam logic [7:0] ALL_ONES = 8'hFF;
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] CTRL_OFS   = 8'h04;
	localparam logic [31:0] CTRL_RST  = 32'h00000001;
	localparam int ST_SHORT = 8;
	localparam int ST_OVH   = 16;
	localparam int ST_CLKF  = 17;
	localparam int ST_ALERT = 18;
	localparam int ST_SEL   = 19;
	localparam logic [1:0] SEL_OFF  = 2'h0;
	localparam logic [1:0] SEL_EXT  = 2'h1;
	localparam logic [1:0] SEL_STBY = 2'h2;
	localparam logic [1:0] SEL_INT  = 2'h3;
	typedef struct packed {
		logic       stop;
		logic       all;
		logic       single;
		logic [2:0] chan;
		logic [7:0] data;
	} wr_cmd_s;
	typedef struct packed {
		logic [NCH-1:0] open_abs;
		logic [NCH-1:0] open_thr;
		logic [NCH-1:0] short_thr;
		logic           over_temp;
		logic           temp_cool;
	} sense_s;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_TX, ST_SKIP} i2c_state_e;
endpackage : fam_pkg

// ### sim/i2c_master_model.sv
`timescale 1ns/1ps
module i2c_master_model (
	// clock
	input  wire logic pclk,
	// bus wires
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task w(input int n);
		repeat (n) @(posedge pclk);
	endtask : w
	// 8 pclk per bit; sda moves one edge after scl falls, never with it
	task bit_io(input logic b, output logic r);
		sda_low <= !b;
		w(3);
		scl <= 1'b1;
		w(2);
		r = sda;
		w(2);
		scl <= 1'b0;
		w(1);
	endtask : bit_io
	task start();
		sda_low <= 1'b1;
		w(4);
		scl <= 1'b0;
		w(1);
	endtask : start
	// scl parked high and sda released between frames
	task stop();
		sda_low <= 1'b1;
		w(4);
		scl <= 1'b1;
		w(4);
		sda_low <= 1'b0;
		w(4);
	endtask : stop
	// eight bits out, ninth released: ack in, or master nack
	task xfer(input logic [7:0] d, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(1'b1, a);
	endtask : xfer
endmodule : i2c_master_model

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top import fam_pkg::*; ;
	localparam int WDT = 200;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack, ea;
	logic [7:0]  paddr, rb, eo, es;
	logic [31:0] pwdata, prdata, q;
	logic        scl, sda_low, sda_w, sda_out, sda_oe, an_out, an_oe;
	logic [3:0]  addr_pins;
	logic        ena, dclk, run, rt_fit, dcr, dload;
	logic [7:0]  fo;
	logic [1:0]  sel, esel;
	sense_s      sense;
	wr_cmd_s     wr_cmd;
	int          failures, checks_done, seed, dcr_n, dl_n, dcnt, ch, k;
	fault_alert_manager #(.WDT_CYCLES(WDT)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .alert_n_out(an_out), .alert_n_oe(an_oe), .addr_pins(addr_pins),
		.high_side_enable_pin(ena), .dimming_clock_input(dclk), .rt_resistor_fitted(rt_fit),
		.sense(sense), .wr_cmd(wr_cmd), .switch_force_on(fo), .dim_clk_sel(sel),
		.dim_counter_reset(dcr), .defaults_load(dload));
	assign sda_w = !(sda_low | (sda_oe & !sda_out));
	i2c_master_model m (.pclk(pclk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// clock input 2 us period, well above the standby rate
	always @(posedge pclk) begin
		dcnt <= (dcnt == 9) ? 0 : dcnt + 1;
		if (dcnt == 9 && run) dclk <= ~dclk;
		if (presetn && dcr) dcr_n <= dcr_n + 1;
		if (presetn && dload) dl_n <= dl_n + 1;
	end
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task cmd(input logic a, input int c, input logic [7:0] d);
		wr_cmd <= '{1'b1, a, !a, 3'(c), d};
		@(posedge pclk) wr_cmd.stop <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask : cmd
	task st();
		apb(1'b0, STATUS_OFS, 32'h0);
		chk("open", 32'(q[7:0]), 32'(eo));
		chk("short", 32'(q[15:8]), 32'(es));
		chk("alert", 32'({q[ST_ALERT], an_oe, !(an_oe & !an_out)}), 32'({ea, ea, !ea}));
		chk("clksel", 32'({q[20:19], sel}), 32'({esel, esel}));
		chk("clkfault", 32'(q[ST_CLKF]), 32'(esel == SEL_STBY));
		chk("overheat", 32'(q[ST_OVH]), 32'(eo == 8'hFF && es == 8'hFF));
	endtask : st
	task ara(input logic [7:0] d, output logic a, output logic [7:0] r);
		logic [7:0] x;
		m.start();
		m.xfer(ARA_RD, x, a);
		if (a === 1'b0) m.xfer(d, r, x[0]);
		m.stop();
	endtask : ara
	task wrap_up();
		if (failures == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (30000) @(posedge pclk);
		failures++;
		wrap_up();
	end
	initial begin
		seed = 80395;
		{presetn, psel, penable, pwrite, paddr, pwdata, ena, dclk, rt_fit, ea, eo, es} = '0;
		{dcnt, dcr_n, dl_n, failures, checks_done} = '0;
		sense = '0;
		wr_cmd = '0;
		run = 1'b1;
		esel = SEL_OFF;
		addr_pins = 4'($random(seed));
		ch = {$random(seed)} % 8;
		k = (ch + 1) % 8;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl reset", q, CTRL_RST);
		// watchdog off until its own test, though every frame here ends within its 200 cycles
		apb(1'b1, CTRL_OFS, 32'hFFFFFFFE);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk("ctrl", q, 32'h0);
		apb(1'b1, 8'h0C, 32'h12345678);
		chk("unmapped", {q[30:0], err}, 32'h1);
		st();
		ena <= 1'b1;
		repeat (6) @(posedge pclk);
		esel = SEL_EXT;
		st();
		ara(8'hFF, ack, rb);
		chk("idle ack", 32'(ack), 32'h1);
		sense.open_abs[ch] <= 1'b1;
		repeat (6) @(posedge pclk);
		sense.open_abs[ch] <= 1'b0;
		eo[ch] = 1'b1;
		ea = 1'b1;
		chk("force", 32'(fo), 32'(eo));
		st();
		ara(8'h00, ack, rb);
		st();
		ara(8'hFF, ack, rb);
		chk("reply", 32'(rb), 32'({ADDR_PFX, addr_pins, 1'b1}));
		repeat (3) @(posedge pclk);
		ea = 1'b0;
		st();
		ara(8'hFF, ack, rb);
		chk("rearm ack", 32'(ack), 32'h1);
		sense.short_thr[k] <= 1'b1;
		repeat (FILT_CYC - 30) @(posedge pclk);
		sense.short_thr[k] <= 1'b0;
		repeat (6) @(posedge pclk);
		st();
		sense.short_thr[k] <= 1'b1;
		repeat (FILT_CYC + 10) @(posedge pclk);
		es[k] = 1'b1;
		ea = 1'b1;
		st();
		chk("force dim", 32'(fo), 32'(eo));
		sense.short_thr[k] <= 1'b0;
		repeat (5) @(posedge pclk);
		cmd(1'b0, k, 8'h00);
		es[k] = 1'b0;
		st();
		sense.open_abs[ch] <= 1'b1;
		repeat (4) @(posedge pclk);
		cmd(1'b1, 0, 8'h00);
		st();
		sense.open_abs[ch] <= 1'b0;
		repeat (5) @(posedge pclk);
		cmd(1'b1, 0, 8'h00);
		{eo, ea} = '0;
		st();
		chk("unforce", 32'(fo), 32'h0);
		sense.over_temp <= 1'b1;
		repeat (6) @(posedge pclk);
		sense.over_temp <= 1'b0;
		{eo, es, ea} = {8'hFF, 8'hFF, 1'b1};
		st();
		chk("force all", 32'(fo), 32'hFF);
		cmd(1'b1, 0, ALL_ONES);
		sense.temp_cool <= 1'b1;
		cmd(1'b0, ch, 8'h00);
		cmd(1'b1, 0, 8'h55);
		st();
		cmd(1'b1, 0, ALL_ONES);
		{eo, es, ea} = '0;
		st();
		run <= 1'b0;
		repeat (150) @(posedge pclk);
		esel = SEL_STBY;
		ea = 1'b1;
		st();
		run <= 1'b1;
		repeat (60) @(posedge pclk);
		st();
		k = dcr_n;
		m.start();
		m.xfer(BCAST_WR, rb, ack);
		chk("bcast ack", 32'(ack), 32'h0);
		m.stop();
		repeat (4) @(posedge pclk);
		{esel, ea} = {SEL_EXT, 1'b0};
		st();
		chk("counter reset", 32'(dcr_n - k), 32'h1);
		rt_fit <= 1'b1;
		run <= 1'b0;
		repeat (150) @(posedge pclk);
		esel = SEL_INT;
		st();
		run <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h1);
		sense.open_abs[ch] <= 1'b1;
		repeat (6) @(posedge pclk);
		sense.open_abs[ch] <= 1'b0;
		{eo[ch], ea} = 2'h3;
		st();
		k = dl_n;
		m.start();
		repeat (WDT - 10) @(posedge pclk);
		chk("early timeout", 32'(dl_n - k), 32'h0);
		repeat (30) @(posedge pclk);
		chk("timeout", 32'(dl_n - k), 32'h1);
		m.stop();
		{esel, eo, ea} = {SEL_EXT, 8'h00, 1'b0};
		st();
		wrap_up();
	end
endmodule : tb_top
